/* File: mrsu_map.svh */
// Constants of the multi-register store unit: encodings, fields, offsets.
// Assumes little-endian bit numbering in the instruction word (bit 31 = msb).
`ifndef MRSU_MAP_SVH
`define MRSU_MAP_SVH
// ------------------------------------------------------------
// Instruction fields
// ------------------------------------------------------------
`define MRSU_F_OPC 31:26
`define MRSU_F_SRC 25:21
`define MRSU_F_BASE 20:16
`define MRSU_F_IDX 15:11
`define MRSU_F_BCNT 15:11
`define MRSU_F_D 15:0
`define MRSU_F_SDISP 15:2
`define MRSU_SRC_ODD_BIT 21
`define MRSU_D_SIGN 15
`define MRSU_F_SUB 1:0
`define MRSU_F_XO 10:1
`define MRSU_OP_STM 6'h2f
`define MRSU_OP_STQ 6'h3e
`define MRSU_OP_X 6'h1f
`define MRSU_OP_STW 6'h24
`define MRSU_STQ_SUB 2'h2
`define MRSU_XO_STSI 10'h2d5
`define MRSU_XO_STSX 10'h295
// ------------------------------------------------------------
// Counts and steps
// ------------------------------------------------------------
`define MRSU_NREGS 8'h20
`define MRSU_NB_ZERO 8'h20
`define MRSU_QUAD_BEATS 8'h02
`define MRSU_ONE 8'h01
`define MRSU_LAST_BYTE 2'h3
`define MRSU_STEP_B 64'h1
`define MRSU_STEP_W 64'h4
`define MRSU_STEP_D 64'h8
// ------------------------------------------------------------
// Register map and reset values
// ------------------------------------------------------------
`define MRSU_OFF_CTRL 12'h000
`define MRSU_OFF_STAT 12'h004
`define MRSU_OFF_MASK 12'h008
`define MRSU_OFF_CNT 12'h00c
`define MRSU_CTRL_RST 1'h1
`define MRSU_MASK_RST 3'h0
`define MRSU_BUSY_BIT 8
`endif

/* File: mrsu_mem_model.sv */
// Far-side model: combinational register file and a store memory that logs beats.
// Assumes the unit holds each beat until ready is seen high at a rising edge.
`timescale 1ns/100ps
module mrsu_mem_model (
  // Clock
  input wire logic clk_in,
  // Register file read
  input wire logic [4:0] raddr_in,
  output logic [63:0] rdata_out,
  // Store port
  input wire logic req_in,
  input wire logic [63:0] addr_in,
  input wire logic [63:0] wdata_in,
  input wire logic [1:0] size_in,
  input wire logic slow_in,
  output logic ready_out
);
  logic [63:0] gpr [32];
  logic [63:0] a [128];
  logic [63:0] d [128];
  logic [1:0] s [128];
  int n_beats = 0;

  // The file answers in the same cycle, like the core's read port
  assign rdata_out = gpr[raddr_in];

  // Log each accepted beat; slow mode stalls every other cycle
  initial ready_out = 1'b1;
  always @(posedge clk_in) begin
    if (req_in === 1'b1 && ready_out === 1'b1) begin
      a[n_beats] = addr_in;
      d[n_beats] = wdata_in;
      s[n_beats] = size_in;
      n_beats = n_beats + 1;
    end
    ready_out <= slow_in ? ~ready_out : 1'b1;
  end
endmodule // mrsu_mem_model

/* File: mrsu_pkg.sv */
// Types of the multi-register store unit.
// Assumes mrsu_map.svh is included where the constants are needed.
package mrsu_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_BASE = 3'b001,
    S_INDEX = 3'b010,
    S_SRC = 3'b011,
    S_MEM = 3'b100,
    S_FIN = 3'b101
  } mrsu_state_t;
  // Decoded instruction kinds
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_STM = 3'b001,
    K_STQ = 3'b010,
    K_STSI = 3'b011,
    K_STSX = 3'b100,
    K_STW = 3'b101
  } mrsu_kind_t;
  // Memory beat sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b10,
    SZ_DWORD = 2'b11
  } mrsu_size_t;
endpackage

/* File: mrsu_top.sv */
// Multi-register store unit: decodes store-multiple, quad, string and
// word stores, forms the address and walks the register file.
// Assumes a register file read that answers GPR_RADDR_OUT in the same
// cycle, a memory port that holds a beat until MEM_READY_IN, and APB.
//
// Notes on behaviour
// - Opcode 47 selects store-multiple-word
// - Store words from source_reg through register 31
// - Address is base plus sign-extended displacement
// - Unaligned multiple-word address gives undefined result
// - Exception and condition registers left untouched
// - Opcode 62 sub 2 stores register pair
// - Quad displacement is field times four
// - Odd source_reg in quad store is invalid
// - Quad store traps on 32-bit implementation
// - Opcode 31 extended 725 is immediate string
// - Immediate string address is base or zero
// - Byte count zero means thirty-two bytes
// - Bytes go leftmost first through consecutive registers
// - Extended 661 takes count from exception register
// - Indexed string address is base plus index
// - Legacy string stores leave multiply-quotient undefined
// - Opcode 36 selects single-word store
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "mrsu_map.svh"
module mrsu_top import mrsu_pkg::*; #(
  parameter bit IS_64BIT = 1'b1
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  // Instruction issue
  input wire logic INSN_VALID_IN,
  input wire logic [31:0] INSN_IN,
  output logic INSN_READY_OUT,
  output logic DONE_OUT,
  output logic TRAP_OUT,
  // Register file and exception register
  output logic [4:0] GPR_RADDR_OUT,
  input wire logic [63:0] GPR_RDATA_IN,
  input wire logic [6:0] EXC_COUNT_IN,
  output logic EXC_WE_OUT,
  output logic CR0_WE_OUT,
  output logic MULQ_WE_OUT,
  // Memory store port
  output logic MEM_REQ_OUT,
  output logic [63:0] MEM_ADDR_OUT,
  output logic [63:0] MEM_WDATA_OUT,
  output logic [1:0] MEM_SIZE_OUT,
  input wire logic MEM_READY_IN,
  // APB slave and interrupt
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic [31:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  // Shared by the sequencer and the checks
  function automatic mrsu_kind_t decode(input logic [31:0] w);
    decode = K_NONE;
    case (w[`MRSU_F_OPC])
      `MRSU_OP_STM: decode = K_STM;
      `MRSU_OP_STW: decode = K_STW;
      `MRSU_OP_STQ: begin
        if (w[`MRSU_F_SUB] == `MRSU_STQ_SUB) decode = K_STQ;
      end
      `MRSU_OP_X: begin
        if (w[`MRSU_F_XO] == `MRSU_XO_STSI) decode = K_STSI;
        else if (w[`MRSU_F_XO] == `MRSU_XO_STSX) decode = K_STSX;
      end
      default: decode = K_NONE;
    endcase
  endfunction

  // Leftmost byte of the low word comes first
  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] i);
    case (i)
      2'h0: pick_byte = w[31:24];
      2'h1: pick_byte = w[23:16];
      2'h2: pick_byte = w[15:8];
      default: pick_byte = w[7:0];
    endcase
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  mrsu_state_t state_q;
  mrsu_kind_t kind_q;
  logic ready_q, done_q, trap_q, unal_q, arch_we_q;
  logic [4:0] raddr_q, base_sel_q, src_sel_q, idx_sel_q, reg_q;
  logic [7:0] cnt_q;
  logic [1:0] bidx_q;
  logic [31:0] src_q;
  logic [63:0] disp_q;
  logic mreq_q;
  logic [63:0] maddr_q, mwdata_q;
  mrsu_size_t msize_q;
  logic ctrl_en_q;
  logic [2:0] stat_q, mask_q;
  logic [31:0] retired_q;
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;

  logic acc;
  logic [63:0] base_v;
  mrsu_kind_t acc_kind;
  assign acc = INSN_VALID_IN & ready_q;
  assign acc_kind = decode(INSN_IN);
  // Register 0 as a base means the value zero, not its contents
  assign base_v = (base_sel_q == 5'h00) ? 64'h0 : GPR_RDATA_IN;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // One beat per word or per register of a quad pair, one beat per string byte
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state_q <= S_IDLE;
      kind_q <= K_NONE;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      trap_q <= 1'b0;
      unal_q <= 1'b0;
      raddr_q <= 5'h00;
      base_sel_q <= 5'h00;
      src_sel_q <= 5'h00;
      idx_sel_q <= 5'h00;
      reg_q <= 5'h00;
      cnt_q <= 8'h00;
      bidx_q <= 2'h0;
      src_q <= 32'h0;
      disp_q <= 64'h0;
      mreq_q <= 1'b0;
      maddr_q <= 64'h0;
      mwdata_q <= 64'h0;
      msize_q <= SZ_BYTE;
    end else begin
      done_q <= 1'b0;
      trap_q <= 1'b0;
      unal_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          ready_q <= ctrl_en_q;
          if (acc) begin
            kind_q <= acc_kind;
            src_sel_q <= INSN_IN[`MRSU_F_SRC];
            base_sel_q <= INSN_IN[`MRSU_F_BASE];
            idx_sel_q <= INSN_IN[`MRSU_F_IDX];
            // Odd pair or a 32-bit core refuses the quad store
            if (acc_kind == K_NONE || (acc_kind == K_STQ &&
                (!IS_64BIT || INSN_IN[`MRSU_SRC_ODD_BIT]))) begin
              trap_q <= 1'b1;
            end else begin
              ready_q <= 1'b0;
              raddr_q <= INSN_IN[`MRSU_F_BASE];
              state_q <= S_BASE;
              disp_q <= {{48{INSN_IN[`MRSU_D_SIGN]}}, INSN_IN[`MRSU_F_D]};
              case (acc_kind)
                K_STM: cnt_q <= `MRSU_NREGS - {3'h0, INSN_IN[`MRSU_F_SRC]};
                K_STQ: begin
                  cnt_q <= `MRSU_QUAD_BEATS;
                  disp_q <= {{48{INSN_IN[`MRSU_D_SIGN]}}, INSN_IN[`MRSU_F_SDISP], 2'h0};
                end
                K_STSI: begin
                  disp_q <= 64'h0;
                  cnt_q <= (INSN_IN[`MRSU_F_BCNT] == 5'h00) ? `MRSU_NB_ZERO :
                           {3'h0, INSN_IN[`MRSU_F_BCNT]};
                end
                K_STSX: cnt_q <= {1'b0, EXC_COUNT_IN};
                default: cnt_q <= `MRSU_ONE;
              endcase
            end
          end
        end
        S_BASE: begin
          if (kind_q == K_STSX) begin
            maddr_q <= base_v;
            raddr_q <= idx_sel_q;
            state_q <= S_INDEX;
          end else begin
            maddr_q <= base_v + disp_q;
            raddr_q <= src_sel_q;
            reg_q <= src_sel_q;
            state_q <= S_SRC;
            // Misaligned multiple-word store is flagged, data still goes out
            unal_q <= (kind_q == K_STM) && ((base_v[1:0] + disp_q[1:0]) != 2'h0);
          end
        end
        S_INDEX: begin
          maddr_q <= maddr_q + GPR_RDATA_IN;
          raddr_q <= src_sel_q;
          reg_q <= src_sel_q;
          state_q <= (cnt_q == 8'h00) ? S_FIN : S_SRC;
        end
        S_SRC: begin
          src_q <= GPR_RDATA_IN[31:0];
          bidx_q <= 2'h0;
          mreq_q <= 1'b1;
          state_q <= S_MEM;
          case (kind_q)
            K_STQ: begin
              msize_q <= SZ_DWORD;
              mwdata_q <= GPR_RDATA_IN;
            end
            K_STSI, K_STSX: begin
              msize_q <= SZ_BYTE;
              mwdata_q <= {56'h0, GPR_RDATA_IN[31:24]};
            end
            default: begin
              msize_q <= SZ_WORD;
              mwdata_q <= {32'h0, GPR_RDATA_IN[31:0]};
            end
          endcase
        end
        S_MEM: begin
          if (MEM_READY_IN) begin
            mreq_q <= 1'b0;
            cnt_q <= cnt_q - `MRSU_ONE;
            case (msize_q)
              SZ_DWORD: maddr_q <= maddr_q + `MRSU_STEP_D;
              SZ_WORD: maddr_q <= maddr_q + `MRSU_STEP_W;
              default: maddr_q <= maddr_q + `MRSU_STEP_B;
            endcase
            if (cnt_q == `MRSU_ONE) begin
              state_q <= S_FIN;
            end else if (msize_q == SZ_BYTE && bidx_q != `MRSU_LAST_BYTE) begin
              // Next byte of the same register, no new read needed
              bidx_q <= bidx_q + 2'h1;
              mreq_q <= 1'b1;
              mwdata_q <= {56'h0, pick_byte(src_q, bidx_q + 2'h1)};
            end else begin
              // Register numbers wrap from 31 to 0 for strings
              reg_q <= reg_q + 5'h01;
              raddr_q <= reg_q + 5'h01;
              state_q <= S_SRC;
            end
          end
        end
        S_FIN: begin
          done_q <= 1'b1;
          ready_q <= ctrl_en_q;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Architected side effects
  // ------------------------------------------------------------
  // None of these stores writes exception, condition or quotient state;
  // the quotient register is simply left as it was, a legal undefined.
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) arch_we_q <= 1'b0;
    else arch_we_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  logic apb_wr, apb_setup, w1c_hit;
  assign apb_setup = PSEL_IN & ~PENABLE_IN;
  assign apb_wr = PSEL_IN & PENABLE_IN & pready_q & PWRITE_IN;
  assign w1c_hit = apb_wr && (PADDR_IN == `MRSU_OFF_STAT);

  // Answer one cycle after setup; read data captured at setup
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      if (apb_setup) begin
        pslverr_q <= 1'b0;
        case (PADDR_IN)
          `MRSU_OFF_CTRL: prdata_q <= {31'h0, ctrl_en_q};
          `MRSU_OFF_STAT: prdata_q <= {23'h0, (state_q != S_IDLE), 5'h0, stat_q};
          `MRSU_OFF_MASK: prdata_q <= {29'h0, mask_q};
          `MRSU_OFF_CNT: prdata_q <= retired_q;
          default: begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // Control and mask writes
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctrl_en_q <= `MRSU_CTRL_RST;
      mask_q <= `MRSU_MASK_RST;
    end else if (apb_wr) begin
      if (PADDR_IN == `MRSU_OFF_CTRL) ctrl_en_q <= PWDATA_IN[0];
      if (PADDR_IN == `MRSU_OFF_MASK) mask_q <= PWDATA_IN[2:0];
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      stat_q <= 3'h0;
      irq_q <= 1'b0;
      retired_q <= 32'h0;
    end else begin
      stat_q <= (stat_q & ~(w1c_hit ? PWDATA_IN[2:0] : 3'h0)) | {unal_q, trap_q, done_q};
      irq_q <= |(stat_q & mask_q);
      if (done_q) retired_q <= retired_q + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign INSN_READY_OUT = ready_q;
  assign DONE_OUT = done_q;
  assign TRAP_OUT = trap_q;
  assign GPR_RADDR_OUT = raddr_q;
  assign EXC_WE_OUT = arch_we_q;
  assign CR0_WE_OUT = arch_we_q;
  assign MULQ_WE_OUT = arch_we_q;
  assign MEM_REQ_OUT = mreq_q;
  assign MEM_ADDR_OUT = maddr_q;
  assign MEM_WDATA_OUT = mwdata_q;
  assign MEM_SIZE_OUT = msize_q;
  assign PREADY_OUT = pready_q;
  assign PRDATA_OUT = prdata_q;
  assign PSLVERR_OUT = pslverr_q;
  assign IRQ_OUT = irq_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_stm_count: assert property (acc && acc_kind == K_STM |=>
    cnt_q == `MRSU_NREGS - {3'h0, $past(INSN_IN[`MRSU_F_SRC])})
    else $error("store-multiple count wrong");
  a_stm_addr: assert property (state_q == S_BASE && kind_q == K_STM |=>
    maddr_q == $past(base_v) + $past(disp_q))
    else $error("store-multiple address wrong");
  a_quad_trap: assert property (acc && acc_kind == K_STQ &&
    (!IS_64BIT || INSN_IN[`MRSU_SRC_ODD_BIT]) |=> TRAP_OUT && state_q == S_IDLE)
    else $error("illegal quad store not trapped");
  a_nb_zero: assert property (acc && acc_kind == K_STSI &&
    INSN_IN[`MRSU_F_BCNT] == 5'h00 |=> cnt_q == `MRSU_NB_ZERO)
    else $error("zero byte count not thirty-two");
  a_zero_count: assert property (state_q == S_INDEX && cnt_q == 8'h00 |=>
    !MEM_REQ_OUT [*2] ##0 DONE_OUT)
    else $error("zero-count string wrote memory");
  a_str_bytes: assert property (MEM_REQ_OUT &&
    (kind_q == K_STSI || kind_q == K_STSX) |-> MEM_SIZE_OUT == SZ_BYTE)
    else $error("string beat not a byte");
  a_mem_hold: assert property (MEM_REQ_OUT && !MEM_READY_IN |=>
    MEM_REQ_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_WDATA_OUT))
    else $error("memory beat dropped before ready");
  a_arch_quiet: assert property (state_q != S_IDLE |->
    !EXC_WE_OUT && !CR0_WE_OUT && !MULQ_WE_OUT)
    else $error("architected state written");
  a_quad_data: assert property (state_q == S_SRC && kind_q == K_STQ |=>
    MEM_WDATA_OUT == $past(GPR_RDATA_IN) && MEM_SIZE_OUT == SZ_DWORD)
    else $error("quad beat data wrong");

  c_stm: cover property (DONE_OUT && kind_q == K_STM);
  c_stq: cover property (DONE_OUT && kind_q == K_STQ);
  c_stsx: cover property (DONE_OUT && kind_q == K_STSX);
  c_trap: cover property (TRAP_OUT);

endmodule // mrsu_top

/* File: tb.sv */
// Self-checking bench for the multi-register store unit.
// Assumes mrsu_map.svh on the include path and the far-side model beside it.
`timescale 1ns/100ps
`include "mrsu_map.svh"
module tb import mrsu_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iv = 1'b0;
  logic [31:0] insn = 32'h0;
  logic [6:0] xc = 7'h0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic ready, done, trap, mreq, mrdy, pready, pslverr, irq, xwe, cwe, mwe, perr, tr;
  logic [4:0] raddr;
  logic [63:0] rdata, maddr, mwdata;
  logic [1:0] msize;
  logic [31:0] prdata, prd;
  logic [63:0] g [32];
  logic trap32;
  int n_trap32 = 0;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int base;

  // Clock at 125 MHz
  always #4 clk = ~clk;

  mrsu_top #(.IS_64BIT(1'b1)) DUT (
    .REF_CLK_IN(clk), .RESET_IN(rst),
    .INSN_VALID_IN(iv), .INSN_IN(insn), .INSN_READY_OUT(ready),
    .DONE_OUT(done), .TRAP_OUT(trap),
    .GPR_RADDR_OUT(raddr), .GPR_RDATA_IN(rdata), .EXC_COUNT_IN(xc),
    .EXC_WE_OUT(xwe), .CR0_WE_OUT(cwe), .MULQ_WE_OUT(mwe),
    .MEM_REQ_OUT(mreq), .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwdata),
    .MEM_SIZE_OUT(msize), .MEM_READY_IN(mrdy),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
    .PSLVERR_OUT(pslverr), .IRQ_OUT(irq)
  );

  // Same instruction stream on a 32-bit core: every quad store must trap there
  mrsu_top #(.IS_64BIT(1'b0)) DUT32 (
    .REF_CLK_IN(clk), .RESET_IN(rst),
    .INSN_VALID_IN(iv), .INSN_IN(insn), .INSN_READY_OUT(),
    .DONE_OUT(), .TRAP_OUT(trap32),
    .GPR_RADDR_OUT(), .GPR_RDATA_IN(64'h0), .EXC_COUNT_IN(xc),
    .EXC_WE_OUT(), .CR0_WE_OUT(), .MULQ_WE_OUT(),
    .MEM_REQ_OUT(), .MEM_ADDR_OUT(), .MEM_WDATA_OUT(),
    .MEM_SIZE_OUT(), .MEM_READY_IN(1'b1),
    .PSEL_IN(1'b0), .PENABLE_IN(1'b0), .PWRITE_IN(1'b0), .PADDR_IN(12'h0),
    .PWDATA_IN(32'h0), .PREADY_OUT(), .PRDATA_OUT(),
    .PSLVERR_OUT(), .IRQ_OUT()
  );

  mrsu_mem_model MEM (
    .clk_in(clk), .raddr_in(raddr), .rdata_out(rdata),
    .req_in(mreq), .addr_in(maddr), .wdata_in(mwdata), .size_in(msize),
    .slow_in(slow), .ready_out(mrdy)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; an idle cycle follows so psel is never driven twice at one edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // The wait ends once pready is seen high; a hang is left to the bench timeout
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rreg(input logic [11:0] ad, input logic [31:0] exp, input string what);
    apb(1'b0, ad, 32'h0);
    chk(what, {32'h0, exp}, {32'h0, prd});
  endtask

  task automatic wreg(input logic [11:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask

  function automatic logic [31:0] xf(input logic [4:0] src, bas, idx, input logic [9:0] xo);
    return {`MRSU_OP_X, src, bas, idx, xo, 1'b0};
  endfunction

  // Offer one instruction, wait for done or trap, then check trap and beat count
  task automatic go(input logic [31:0] w, input logic [6:0] cnt, input logic etr, input int enb);
    base = MEM.n_beats;
    insn <= w;
    xc <= cnt;
    iv <= 1'b1;
    do begin
      @(posedge clk);
    end while (ready !== 1'b1);
    iv <= 1'b0;
    do begin
      @(posedge clk);
      tr = trap;
    end while (done !== 1'b1 && tr !== 1'b1);
    chk("trap", {63'h0, etr}, {63'h0, tr});
    chk("beat count", 64'(enb), 64'(MEM.n_beats - base));
  endtask

  // Data is right-justified, so only the bytes of the beat size are compared
  task automatic beat(input int k, input logic [63:0] addr, input mrsu_size_t sz,
                      input logic [63:0] dat);
    logic [63:0] m;
    m = (sz == SZ_BYTE) ? 64'hff : (sz == SZ_WORD) ? 64'hffff_ffff : 64'hffff_ffff_ffff_ffff;
    chk("beat addr", addr, MEM.a[base + k]);
    chk("beat size", {62'h0, sz}, {62'h0, MEM.s[base + k]});
    chk("beat data", dat & m, MEM.d[base + k] & m);
  endtask

  task automatic strrun(input logic [31:0] w, input logic [6:0] cnt, input logic [4:0] src,
                        input logic [63:0] start, input int n);
    go(w, cnt, 1'b0, n);
    for (int j = 0; j < n; j++) begin
      beat(j, start + 64'(j), SZ_BYTE, {56'h0, g[5'(src + j / 4)][31 - 8 * (j % 4) -: 8]});
    end
  endtask

  // Architected side registers must never be written; a hang is cut short
  always @(posedge clk) begin
    // Outputs are unknown until the first reset edge, so look only once out of reset
    if (!rst) chk("state writes", 64'h0, {61'h0, xwe, cwe, mwe});
    if (trap32 === 1'b1) n_trap32++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 32; i++) begin
      g[i] = {24'hc0de00, 8'(i), 8'(i + 8'h80), 8'(i + 8'ha0), 8'(i + 8'hc0), 8'(i + 8'he0)};
    end
    g[4] = 64'h1000;
    g[5] = 64'h7;
    MEM.gpr = g;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rreg(`MRSU_OFF_CTRL, 32'h1, "ctrl reset");
    rreg(`MRSU_OFF_MASK, 32'h0, "mask reset");
    rreg(12'h010, 32'h0, "unmapped data");
    chk("unmapped err", 64'h1, {63'h0, perr});
    go({`MRSU_OP_STM, 5'h1d, 5'h04, 16'hfff8}, 7'h0, 1'b0, 3);
    for (int k = 0; k < 3; k++) begin
      beat(k, 64'h0ff8 + 64'(k * 4), SZ_WORD, g[29 + k]);
    end
    slow <= 1'b1;
    go({`MRSU_OP_STM, 5'h1e, 5'h00, 16'h0100}, 7'h0, 1'b0, 2);
    for (int k = 0; k < 2; k++) begin
      beat(k, 64'h0100 + 64'(k * 4), SZ_WORD, g[30 + k]);
    end
    slow <= 1'b0;
    rreg(`MRSU_OFF_CNT, 32'h2, "retired count");
    go({`MRSU_OP_STQ, 5'h06, 5'h04, 14'h3ffe, `MRSU_STQ_SUB}, 7'h0, 1'b0, 2);
    for (int k = 0; k < 2; k++) begin
      beat(k, 64'h0ff8 + 64'(k * 8), SZ_DWORD, g[6 + k]);
    end
    go({`MRSU_OP_STQ, 5'h07, 5'h04, 14'h0001, `MRSU_STQ_SUB}, 7'h0, 1'b1, 0);
    strrun(xf(5'h06, 5'h04, 5'h05, `MRSU_XO_STSI), 7'h0, 5'h06, 64'h1000, 5);
    slow <= 1'b1;
    strrun(xf(5'h1e, 5'h00, 5'h00, `MRSU_XO_STSI), 7'h0, 5'h1e, 64'h0, 32);
    slow <= 1'b0;
    strrun(xf(5'h06, 5'h04, 5'h05, `MRSU_XO_STSX), 7'h06, 5'h06, 64'h1007, 6);
    strrun(xf(5'h1f, 5'h00, 5'h05, `MRSU_XO_STSX), 7'h03, 5'h1f, 64'h7, 3);
    go(xf(5'h06, 5'h04, 5'h05, `MRSU_XO_STSX), 7'h00, 1'b0, 0);
    go({`MRSU_OP_STW, 5'h06, 5'h04, 16'h0004}, 7'h0, 1'b0, 1);
    beat(0, 64'h1004, SZ_WORD, g[6]);
    // Refusals raise the trap flag; interrupt is masked, unmasked, then cleared
    wreg(`MRSU_OFF_STAT, 32'h7);
    go(32'h0, 7'h0, 1'b1, 0);
    go(xf(5'h00, 5'h00, 5'h00, 10'h001), 7'h0, 1'b1, 0);
    rreg(`MRSU_OFF_STAT, 32'h2, "trap status");
    chk("irq masked", 64'h0, {63'h0, irq});
    wreg(`MRSU_OFF_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq raised", 64'h1, {63'h0, irq});
    wreg(`MRSU_OFF_STAT, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 64'h0, {63'h0, irq});
    go({`MRSU_OP_STM, 5'h1f, 5'h04, 16'h0002}, 7'h0, 1'b0, 1);
    beat(0, 64'h1002, SZ_WORD, g[31]);
    rreg(`MRSU_OFF_STAT, 32'h5, "unaligned status");
    // Clearing the enable must stop the unit taking instructions
    wreg(`MRSU_OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("ready gated", 64'h0, {63'h0, ready});
    wreg(`MRSU_OFF_CTRL, 32'h1);
    // Two quad stores and two unknown words were offered to the 32-bit core
    chk("32-bit traps", 64'h4, 64'(n_trap32));
    close_out();
  end
endmodule // tb
